// file: dv/tb_timer_capture_compare_channels.sv
// Self-checking testbench for the timer capture/compare channels
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb_timer_capture_compare_channels;
    import tcc_pkg::*;
    logic        core_clk      = 1'b0;
    logic        reset_n       = 1'b0;
    logic [15:0] reg_addr      = 16'h0000;
    logic        reg_wr        = 1'b0;
    logic [7:0]  reg_wdata     = 8'h00;
    logic [7:0]  reg_rdata;
    logic [15:0] timer_counter = 16'h0005;
    logic [15:0] ch0_value     = 16'h0100;
    logic        count_down    = 1'b0;
    logic        up_down_mode  = 1'b0;
    logic [2:0]  capture_pin   = 3'h0;
    logic        radio_irq     = 1'b0;
    logic [2:0]  out_pin;
    logic [2:0]  irq_req;
    int          err_count     = 0;
    int          checks        = 0;
    int          cycles        = 0;
    int          irq_cnt [3]   = '{0, 0, 0};
    logic [15:0] a_ctl [3]     = '{TCC_CH2_CTL, TCC_CH3_CTL, TCC_CH4_CTL};
    logic [15:0] a_low [3]     = '{TCC_CH2_LOW, TCC_CH3_LOW, TCC_CH4_LOW};
    logic [15:0] a_high [3]    = '{TCC_CH2_HIGH, TCC_CH3_HIGH, TCC_CH4_HIGH};

    tcc_top uut (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .reg_addr      (reg_addr),
        .reg_wr        (reg_wr),
        .reg_wdata     (reg_wdata),
        .reg_rdata     (reg_rdata),
        .timer_counter (timer_counter),
        .ch0_value     (ch0_value),
        .count_down    (count_down),
        .up_down_mode  (up_down_mode),
        .capture_pin   (capture_pin),
        .radio_irq     (radio_irq),
        .out_pin       (out_pin),
        .irq_req       (irq_req)
    );

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task final_report;
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Pulse counter per channel; also cuts a hang short
    always @(posedge core_clk) begin
        cycles++;
        for (int i = 0; i < 3; i++) begin
            if (irq_req[i] === 1'b1) irq_cnt[i]++;
        end
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data is registered, so it is judged one edge after the address
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        @(posedge core_clk);
        #1;
        `CHK(reg_rdata, e)
    endtask

    task rd16(input int c, input logic [15:0] e);
        rd(a_low[c], e[7:0]);
        rd(a_high[c], e[15:8]);
    endtask

    // Counter sits on v for exactly one edge, so a toggle happens once
    task act(input logic [15:0] v, input logic ud, input logic dn, input logic e);
        @(posedge core_clk);
        timer_counter <= v;
        up_down_mode  <= ud;
        count_down    <= dn;
        @(posedge core_clk);
        timer_counter <= 16'h0005;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(out_pin[0], e)
    endtask

    task cap(input int c, input logic [7:0] ctl, input logic p, input logic r,
             input logic [15:0] cnt, input logic [15:0] e, input int ei);
        int n0;
        wr(a_ctl[c], ctl);
        n0 = irq_cnt[c];
        @(posedge core_clk);
        capture_pin[c] <= p;
        radio_irq      <= r;
        timer_counter  <= cnt;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK(irq_cnt[c] - n0, ei)
        rd16(c, e);
    endtask

    task s_reset;
        for (int c = 0; c < 3; c++) begin
            rd(a_ctl[c], TCC_CTL_RESET);
            rd16(c, TCC_COUNT_ZERO);
        end
        wr(16'h62A5, 8'hFF);
        rd(16'h62A5, TCC_BYTE_ZERO);
    endtask

    task s_buffer;
        wr(a_low[1], 8'h78);
        rd(a_low[1], 8'h00);
        wr(a_high[1], 8'h56);
        rd16(1, 16'h5678);
    endtask

    task s_defer;
        wr(a_ctl[0], 8'h44);
        wr(a_low[0], 8'h34);
        wr(a_high[0], 8'h12);
        rd16(0, 16'h0000);
        @(posedge core_clk);
        timer_counter <= 16'h0000;
        @(posedge core_clk);
        timer_counter <= 16'h0005;
        rd16(0, 16'h1234);
    endtask

    // Init first so the set action starts from a low pin and can be seen to act
    task s_actions;
        wr(a_ctl[0], 8'h7C);
        rd(a_ctl[0], 8'h44);
        `CHK(out_pin[0], 1'b0)
        act(16'h1234, 1'b0, 1'b0, 1'b1);
        wr(a_ctl[0], 8'h4C);
        act(16'h0100, 1'b0, 1'b0, 1'b1);
        act(16'h1234, 1'b0, 1'b0, 1'b0);
        wr(a_ctl[0], 8'h54);
        act(16'h1234, 1'b0, 1'b0, 1'b1);
        act(16'h1234, 1'b0, 1'b0, 1'b0);
        wr(a_ctl[0], 8'h5C);
        act(16'h1234, 1'b0, 1'b0, 1'b1);
        act(16'h0000, 1'b0, 1'b0, 1'b0);
        act(16'h1234, 1'b1, 1'b0, 1'b1);
        act(16'h1234, 1'b1, 1'b1, 1'b0);
        wr(a_ctl[0], 8'h64);
        act(16'h0000, 1'b0, 1'b0, 1'b1);
        act(16'h1234, 1'b0, 1'b0, 1'b0);
        act(16'h1234, 1'b1, 1'b1, 1'b1);
        act(16'h1234, 1'b1, 1'b0, 1'b0);
        wr(a_ctl[0], 8'h6C);
        act(16'h1234, 1'b0, 1'b0, 1'b1);
        act(16'h0100, 1'b0, 1'b0, 1'b0);
        wr(a_ctl[0], 8'h74);
        act(16'h0100, 1'b0, 1'b0, 1'b1);
        act(16'h1234, 1'b0, 1'b0, 1'b0);
    endtask

    task s_capture;
        cap(1, 8'h41, 1'b1, 1'b0, 16'h0A01, 16'h0A01, 1);
        cap(1, 8'h41, 1'b0, 1'b0, 16'h0A02, 16'h0A01, 0);
        cap(1, 8'h42, 1'b1, 1'b0, 16'h0A03, 16'h0A01, 0);
        cap(1, 8'h42, 1'b0, 1'b0, 16'h0A04, 16'h0A04, 1);
        cap(1, 8'h43, 1'b1, 1'b0, 16'h0A05, 16'h0A05, 1);
        cap(1, 8'h43, 1'b0, 1'b0, 16'h0A06, 16'h0A06, 1);
        cap(1, 8'h40, 1'b1, 1'b0, 16'h0A07, 16'h0A06, 0);
        cap(1, 8'h02, 1'b0, 1'b0, 16'h0A08, 16'h0A08, 0);
        cap(2, 8'hC1, 1'b1, 1'b0, 16'h0B01, 16'h0000, 0);
        cap(2, 8'hC1, 1'b1, 1'b1, 16'h0B02, 16'h0B02, 1);
        `CHK(out_pin[2:1], 2'b00)
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        s_reset();
        s_buffer();
        s_defer();
        s_actions();
        s_capture();
        final_report();
    end
endmodule

// file: hw/tcc_channel.sv
// One capture/compare channel: control, buffered value, capture and output action
`timescale 1ns/1ps
module tcc_channel
    import tcc_pkg::*;
#(
    parameter int VAL_W = TCC_VAL_W
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             ctl_we,
    input  wire logic             low_we,
    input  wire logic             high_we,
    input  wire logic [7:0]       wdata,
    input  wire logic [VAL_W-1:0] timer_counter,
    input  wire logic [VAL_W-1:0] ch0_value,
    input  wire logic             count_down,
    input  wire logic             up_down_mode,
    input  wire logic             capture_pin,
    input  wire logic             radio_irq,
    output logic [7:0]            control,
    output logic [VAL_W-1:0]      value,
    output logic                  out_pin,
    output logic                  irq_req
);
    logic [7:0]       low_buf;
    logic [VAL_W-1:0] pending;
    logic             pend_valid;
    logic             src_prev;
    logic             src;
    logic             rise;
    logic             fall;
    logic             cap_hit;
    logic             match;
    logic             match0;
    logic             at_zero;
    logic             compare_mode;
    logic [2:0]       act;
    logic             next_out;

    assign compare_mode = control[TCC_MODE_BIT];
    assign act          = control[TCC_CMP_HI:TCC_CMP_LO];
    assign src          = control[TCC_RADIO_BIT] ? radio_irq : capture_pin;
    assign rise         = src & ~src_prev;
    assign fall         = ~src & src_prev;
    assign at_zero      = (timer_counter == TCC_COUNT_ZERO);
    assign match        = (timer_counter == value);
    assign match0       = (timer_counter == ch0_value);

    always_comb begin
        case (tcc_edge_t'(control[TCC_CAP_HI:TCC_CAP_LO]))
            TCC_CAP_RISE: cap_hit = rise;
            TCC_CAP_FALL: cap_hit = fall;
            TCC_CAP_BOTH: cap_hit = rise | fall;
            default:      cap_hit = 1'b0;
        endcase
        if (compare_mode) begin
            cap_hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= src;
        end
    end

    // Code 111 only strikes the pin; the stored action field is kept
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            control <= TCC_CTL_RESET;
        end else if (ctl_we) begin
            if (wdata[TCC_CMP_HI:TCC_CMP_LO] == TCC_ACT_INIT) begin
                control <= {wdata[TCC_RADIO_BIT:TCC_MASK_BIT],
                            control[TCC_CMP_HI:TCC_CMP_LO],
                            wdata[TCC_MODE_BIT:TCC_CAP_LO]};
            end else begin
                control <= wdata;
            end
        end
    end

    // Low byte never lands alone; it rides with the next high-byte update
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            low_buf    <= TCC_BYTE_ZERO;
            pending    <= '0;
            pend_valid <= 1'b0;
            value      <= '0;
        end else begin
            if (low_we) begin
                low_buf <= wdata;
            end
            if (high_we && compare_mode) begin
                pending    <= {wdata, low_buf};
                pend_valid <= 1'b1;
            end else if (pend_valid && at_zero) begin
                pend_valid <= 1'b0;
            end
            if (high_we && !compare_mode) begin
                value <= {wdata, low_buf};
            end else if (pend_valid && at_zero) begin
                value <= pending;
            end else if (cap_hit) begin
                value <= timer_counter;
            end
        end
    end

    always_comb begin
        next_out = out_pin;
        case (tcc_action_t'(act))
            TCC_ACT_SET:    if (match) next_out = 1'b1;
            TCC_ACT_CLEAR:  if (match) next_out = 1'b0;
            TCC_ACT_TOGGLE: if (match) next_out = ~out_pin;
            TCC_ACT_SET_UP: begin
                if (up_down_mode) begin
                    if (match) next_out = ~count_down;
                end else if (match) begin
                    next_out = 1'b1;
                end else if (at_zero) begin
                    next_out = 1'b0;
                end
            end
            TCC_ACT_CLR_UP: begin
                if (up_down_mode) begin
                    if (match) next_out = count_down;
                end else if (match) begin
                    next_out = 1'b0;
                end else if (at_zero) begin
                    next_out = 1'b1;
                end
            end
            TCC_ACT_CLR_CH0: begin
                if (match) next_out = 1'b1;
                else if (match0) next_out = 1'b0;
            end
            TCC_ACT_SET_CH0: begin
                if (match) next_out = 1'b0;
                else if (match0) next_out = 1'b1;
            end
            default: next_out = out_pin;
        endcase
        if (!compare_mode) begin
            next_out = out_pin;
        end
        if (ctl_we && wdata[TCC_CMP_HI:TCC_CMP_LO] == TCC_ACT_INIT) begin
            next_out = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            out_pin <= 1'b0;
        end else begin
            out_pin <= next_out;
        end
    end

    // Compare events are edge-free: a match held for several ticks raises one pulse per tick
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= control[TCC_MASK_BIT] & (cap_hit | (compare_mode & match));
        end
    end

    a_capture_loads: assert property (@(posedge core_clk) disable iff (!reset_n)
        cap_hit && !high_we && !(pend_valid && at_zero) |=> value == $past(timer_counter))
        else $error("capture did not load counter");
    a_mask_gates_irq: assert property (@(posedge core_clk) disable iff (!reset_n)
        !control[TCC_MASK_BIT] && !ctl_we |=> !irq_req)
        else $error("masked channel raised request");
    a_init_keeps_act: assert property (@(posedge core_clk) disable iff (!reset_n)
        ctl_we && wdata[TCC_CMP_HI:TCC_CMP_LO] == TCC_ACT_INIT |=> $stable(act))
        else $error("action field changed on init");
    a_high_delayed: assert property (@(posedge core_clk) disable iff (!reset_n)
        high_we && compare_mode && !at_zero |=> pend_valid && value == $past(value))
        else $error("compare value updated early");
    a_pend_applies: assert property (@(posedge core_clk) disable iff (!reset_n)
        pend_valid && at_zero && !high_we |=> !pend_valid && value == $past(pending))
        else $error("buffered value not applied at zero");
    a_set_on_match: assert property (@(posedge core_clk) disable iff (!reset_n)
        compare_mode && act == TCC_ACT_SET && match && !ctl_we |=> out_pin)
        else $error("set action missed");
    a_toggle_match: assert property (@(posedge core_clk) disable iff (!reset_n)
        compare_mode && act == TCC_ACT_TOGGLE && match && !ctl_we |=> out_pin != $past(out_pin))
        else $error("toggle action missed");
    a_updown_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        compare_mode && act == TCC_ACT_SET_UP && up_down_mode && match && !ctl_we
        |=> out_pin == !$past(count_down))
        else $error("up-down set action wrong");
    a_ch0_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        compare_mode && act == TCC_ACT_CLR_CH0 && match0 && !match && !ctl_we |=> !out_pin)
        else $error("channel 0 clear missed");
endmodule

// file: hw/tcc_pkg.sv
// Register map, field layout and encodings for the timer capture/compare channels
package tcc_pkg;
    localparam int TCC_ADDR_W = 16;
    localparam int TCC_VAL_W  = 16;
    localparam int TCC_NCH    = 3;

    localparam logic [15:0] TCC_CH2_CTL  = 16'h00E7;
    localparam logic [15:0] TCC_CH2_LOW  = 16'h00DE;
    localparam logic [15:0] TCC_CH2_HIGH = 16'h00DF;
    localparam logic [15:0] TCC_CH3_CTL  = 16'h62A3;
    localparam logic [15:0] TCC_CH3_LOW  = 16'h62AC;
    localparam logic [15:0] TCC_CH3_HIGH = 16'h62AD;
    localparam logic [15:0] TCC_CH4_CTL  = 16'h62A4;
    localparam logic [15:0] TCC_CH4_LOW  = 16'h62AE;
    localparam logic [15:0] TCC_CH4_HIGH = 16'h62AF;

    localparam int TCC_RADIO_BIT = 7;
    localparam int TCC_MASK_BIT  = 6;
    localparam int TCC_CMP_HI    = 5;
    localparam int TCC_CMP_LO    = 3;
    localparam int TCC_MODE_BIT  = 2;
    localparam int TCC_CAP_HI    = 1;
    localparam int TCC_CAP_LO    = 0;

    localparam logic [7:0]  TCC_CTL_RESET = 8'h40;
    localparam logic [7:0]  TCC_BYTE_ZERO = 8'h00;
    localparam logic [15:0] TCC_COUNT_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        TCC_ACT_SET      = 3'h0,
        TCC_ACT_CLEAR    = 3'h1,
        TCC_ACT_TOGGLE   = 3'h2,
        TCC_ACT_SET_UP   = 3'h3,
        TCC_ACT_CLR_UP   = 3'h4,
        TCC_ACT_CLR_CH0  = 3'h5,
        TCC_ACT_SET_CH0  = 3'h6,
        TCC_ACT_INIT     = 3'h7
    } tcc_action_t;

    typedef enum logic [1:0] {
        TCC_CAP_NONE = 2'h0,
        TCC_CAP_RISE = 2'h1,
        TCC_CAP_FALL = 2'h2,
        TCC_CAP_BOTH = 2'h3
    } tcc_edge_t;
endpackage

// file: hw/tcc_top.sv
// Channels 2 to 4 of the timer capture/compare unit with their register decode
`timescale 1ns/1ps
module tcc_top
    import tcc_pkg::*;
#(
    parameter int NCH   = TCC_NCH,
    parameter int VAL_W = TCC_VAL_W
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic [TCC_ADDR_W-1:0] reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_wdata,
    output logic [7:0]                 reg_rdata,
    input  wire logic [VAL_W-1:0]      timer_counter,
    input  wire logic [VAL_W-1:0]      ch0_value,
    input  wire logic                  count_down,
    input  wire logic                  up_down_mode,
    input  wire logic [NCH-1:0]        capture_pin,
    input  wire logic                  radio_irq,
    output logic [NCH-1:0]             out_pin,
    output logic [NCH-1:0]             irq_req
);
    localparam logic [15:0] CTL_ADDR [3]  = '{TCC_CH2_CTL, TCC_CH3_CTL, TCC_CH4_CTL};
    localparam logic [15:0] LOW_ADDR [3]  = '{TCC_CH2_LOW, TCC_CH3_LOW, TCC_CH4_LOW};
    localparam logic [15:0] HIGH_ADDR [3] = '{TCC_CH2_HIGH, TCC_CH3_HIGH, TCC_CH4_HIGH};

    logic [7:0]       control [NCH];
    logic [VAL_W-1:0] value   [NCH];
    logic [7:0]       next_rdata;

    // Reads return live value bytes, not the write buffer
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        tcc_channel #(
            .VAL_W (VAL_W)
        ) u_ch (
            .core_clk      (core_clk),
            .reset_n       (reset_n),
            .ctl_we        (reg_wr && reg_addr == CTL_ADDR[i]),
            .low_we        (reg_wr && reg_addr == LOW_ADDR[i]),
            .high_we       (reg_wr && reg_addr == HIGH_ADDR[i]),
            .wdata         (reg_wdata),
            .timer_counter (timer_counter),
            .ch0_value     (ch0_value),
            .count_down    (count_down),
            .up_down_mode  (up_down_mode),
            .capture_pin   (capture_pin[i]),
            .radio_irq     (radio_irq),
            .control       (control[i]),
            .value         (value[i]),
            .out_pin       (out_pin[i]),
            .irq_req       (irq_req[i])
        );
    end

    always_comb begin
        next_rdata = TCC_BYTE_ZERO;
        for (int i = 0; i < NCH; i++) begin
            if (reg_addr == CTL_ADDR[i]) next_rdata = control[i];
            if (reg_addr == LOW_ADDR[i]) next_rdata = value[i][7:0];
            if (reg_addr == HIGH_ADDR[i]) next_rdata = value[i][15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= TCC_BYTE_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    a_ctl_reset_mask: assert property (@(posedge core_clk)
        $rose(reset_n) |-> control[0] == TCC_CTL_RESET)
        else $error("control reset value wrong");
    a_read_control: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_addr == TCC_CH2_CTL && !reg_wr |=> reg_rdata == $past(control[0]))
        else $error("control readback wrong");
endmodule
